// ---- verilog/bsc_chain_front.sv ----
// Boundary-scan register of 112 cells with tri-state pin control.
// Function
// - 112 cells, cell one nearest serial output
// - control cell one enables, zero tri-states
// - every scanned output pin can tri-state
// - one enable for failure, stall, request
// - one enable for parity and data
// - one enable for bus-control strobes
// - bus grant acknowledge has own enable
// - one enable for address and cycle type
module bsc_chain_front
	import bsc_pkg::*;
(
	input wire logic ref_clk, // System clock, 25 MHz.
	input wire logic resetn, // Synchronous reset, active low.
	input wire logic tck, // Test clock from the tester.
	input wire logic tdi, // Serial test data in.
	input wire logic capture_dr, // Test port in capture state.
	input wire logic shift_dr, // Test port in shift state.
	input wire logic update_dr, // Test port in update state.
	input wire logic extest, // Pins driven from the update stage.
	output logic tdo, // Serial test data out.
	output logic tdo_oe_n, // Low while the serial output drives.
	input wire logic [G_NUM-1:0] core_en, // Functional enables per group.
	input wire logic [31:0] core_data, // Functional data to drive.
	input wire logic [3:0] core_parity, // Functional parity to drive.
	input wire logic [18:0] core_ctl, // Functional control outputs.
	input wire logic [29:0] core_addr, // Functional address 31:2.
	input wire logic [3:0] core_ct, // Functional cycle type.
	input wire logic [31:0] data_line_in, // Data pins as seen.
	output logic [31:0] data_line_out, // Data pins driven value.
	output logic data_line_oe_n, // Low while data pins drive.
	input wire logic [3:0] data_parity_line_in, // Parity pins as seen.
	output logic [3:0] data_parity_line_out, // Parity driven value.
	output logic data_parity_line_oe_n, // Low while parity drives.
	input wire logic [16:0] pin_in, // Plain input pins, see note.
	output logic selftest_failure_n, // Self-test failure.
	output logic bus_stall_indication, // Bus stall.
	output logic bus_request_pending, // Bus request pending.
	output logic grp_fail_oe_n, // Low while the group above drives.
	output logic bus_grant_ack, // Bus grant acknowledge.
	output logic bus_grant_ack_oe_n, // Low while it drives.
	output logic address_strobe_n, // Address strobe.
	output logic [3:0] byte_lane_enable_n, // Byte lane enables.
	output logic final_transfer_n, // Final transfer.
	output logic data_strobe_enable_n, // Data strobe enable.
	output logic write_read_select, // Write or read.
	output logic wait_indicator_n, // Wait indicator.
	output logic data_code_select, // Data or code.
	output logic privilege_level_n, // Privilege level.
	output logic atomic_lock_n, // Atomic lock.
	output logic grp_bus_oe_n, // Low while bus-control group drives.
	output logic data_dir_n, // Data direction.
	output logic data_dir_oe_n, // Low while data direction drives.
	output logic [29:0] address, // Address 31:2.
	output logic [3:0] cycle_type, // Cycle type.
	output logic grp_addr_oe_n, // Low while address group drives.
	output logic parity_check_n, // Parity check.
	output logic parity_check_oe_n // Low while parity check drives.
);
	logic [BSC_LEN-1:0] chain_reg, chain_next;
	logic [BSC_LEN-1:0] upd_reg, upd_next;
	logic [BSC_LEN-1:0] cap;
	logic [5:0] s1_reg, s2_reg;
	logic tck_d_reg;
	logic tck_rise, tck_fall;
	logic [G_NUM-1:0] en;
	logic [17:0] ctl_out;

	// Timing of the chain as seen from the system clock.
	// Every test-side pin passes two flops, so a test clock edge on the
	// pin is acted on three system clocks later.
	// The test clock must stay high and low for at least one system
	// clock each, or an edge can fall between two samples of the first stage.
	// Capture and shift both act on the rising test clock edge.
	// Capture wins when the tester raises both state lines together.
	// The update stage loads on the falling test clock edge only, so the
	// pins never see the chain while it is moving.
	// While the pin test mode is off the pins follow the core values and
	// the chain can still be captured and shifted without harm.
	// The serial output is enabled only while the shift state is seen.
	// Cell position 0 is the stage next to the serial output.
	// Cell position 111 is the stage that receives serial data in.
	// Output cells capture the value presented to their pin, which is
	// the update stage in pin test mode and the core value otherwise.
	// Bidirectional data and parity cells capture the pins as seen.
	// Control cells capture their own update bit, so a capture followed
	// by an update leaves every enable as it was.
	// After reset all update bits are zero, so in pin test mode every
	// driver starts tri-stated until the first update.
	// The control vector below packs eighteen outputs; the top bit of
	// the core control input is a spare and is not driven to any pin.
	// Control vector order from the top: failure, stall, request,
	// grant acknowledge, address strobe, byte lanes 3 to 0, final
	// transfer, data strobe, write or read, wait, data or code,
	// privilege, lock, data direction and parity check.
	// Grouped enables are shared exactly as the control cells are, so a
	// single cell turns a whole group on or off at once.
	// The address and cycle type enable sits further along the chain.

	// Two-flop synchronisers for the test-side pins.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			s1_reg <= 6'h00;
			s2_reg <= 6'h00;
			tck_d_reg <= BSC_RST_BIT;
		end
		else
		begin
			s1_reg <= {tck, tdi, capture_dr, shift_dr, update_dr, extest};
			s2_reg <= s1_reg;
			tck_d_reg <= s2_reg[5];
		end
	end

	// Test clock edges as seen from the system clock.
	assign tck_rise = s2_reg[5] & ~tck_d_reg;
	assign tck_fall = ~s2_reg[5] & tck_d_reg;

	// Capture on a rising edge, shift toward position 0, update on falling.
	assign chain_next = (tck_rise && s2_reg[3]) ? cap :
		(tck_rise && s2_reg[2]) ? {s2_reg[4], chain_reg[BSC_LEN-1:1]} :
		chain_reg;
	assign upd_next = (tck_fall && s2_reg[1]) ? chain_reg : upd_reg;

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			chain_reg <= '0;
			upd_reg <= '0;
		end
		else
		begin
			chain_reg <= chain_next;
			upd_reg <= upd_next;
		end
	end

	// Serial output: cell one, driven only while shifting.
	assign tdo = chain_reg[0];
	assign tdo_oe_n = ~s2_reg[2];

	// Functional control outputs in cell order of the vector below.
	assign ctl_out = s2_reg[0] ? {upd_reg[C_FAIL], upd_reg[C_STALL],
		upd_reg[C_BUS_REQUEST_PENDING], upd_reg[C_BUS_GRANT_ACK], upd_reg[C_ADS],
		upd_reg[C_BE0-3], upd_reg[C_BE0-2], upd_reg[C_BE0-1], upd_reg[C_BE0],
		upd_reg[C_BLAST], upd_reg[C_DEN], upd_reg[C_WRRD], upd_reg[C_WAIT],
		upd_reg[C_DC], upd_reg[C_SUP], upd_reg[C_LOCK], upd_reg[C_DTR],
		upd_reg[C_PCHK]} : core_ctl[17:0];
	assign {selftest_failure_n, bus_stall_indication, bus_request_pending,
		bus_grant_ack, address_strobe_n, byte_lane_enable_n, final_transfer_n,
		data_strobe_enable_n, write_read_select, wait_indicator_n,
		data_code_select, privilege_level_n, atomic_lock_n, data_dir_n,
		parity_check_n} = ctl_out;

	// Group enables: control cell in test mode, core enable otherwise.
	assign en = s2_reg[0] ? {upd_reg[C_EN_PCHK], upd_reg[C_EN_ADDR],
		upd_reg[C_EN_BUS], upd_reg[C_EN_DTR], upd_reg[C_EN_BUS_GRANT_ACK],
		upd_reg[C_EN_DATA], upd_reg[C_EN_FAIL]} : core_en;
	assign grp_fail_oe_n = ~en[G_FAIL];
	assign data_line_oe_n = ~en[G_DATA];
	assign data_parity_line_oe_n = ~en[G_DATA];
	assign bus_grant_ack_oe_n = ~en[G_BUS_GRANT_ACK];
	assign data_dir_oe_n = ~en[G_DTR];
	assign grp_bus_oe_n = ~en[G_BUS];
	assign grp_addr_oe_n = ~en[G_ADDR];
	assign parity_check_oe_n = ~en[G_PCHK];

	// Wide pin groups: update stage in test mode, core value otherwise.
	genvar i;
	generate
		for (i = 0; i < 32; i++)
		begin : g_data
			localparam int P = (i < 8) ? C_D0 + i : C_D8 + i - 8;
			assign data_line_out[i] = s2_reg[0] ? upd_reg[P] : core_data[i];
			assign cap[P] = data_line_in[i];
		end
		for (i = 0; i < 30; i++)
		begin : g_addr
			localparam int P = (i < 14) ? C_A2 - i : C_A16 + 14 - i;
			assign address[i] = s2_reg[0] ? upd_reg[P] : core_addr[i];
			assign cap[P] = address[i];
		end
		for (i = 0; i < 4; i++)
		begin : g_ct
			assign cycle_type[i] = s2_reg[0] ? upd_reg[C_CT0-i] : core_ct[i];
			assign cap[C_CT0-i] = cycle_type[i];
			assign cap[C_BE0-i] = ctl_out[9+i];
		end
		for (i = 0; i < 8; i++)
		begin : g_xint
			assign cap[C_XINT0-i] = pin_in[i];
		end
	endgenerate

	// Parity lines sit in the order 3, 2, 0, 1.
	assign data_parity_line_out = s2_reg[0] ?
		{upd_reg[C_DP3], upd_reg[C_DP2], upd_reg[C_DP1], upd_reg[C_DP0]} :
		core_parity;
	assign {cap[C_DP3], cap[C_DP2], cap[C_DP1], cap[C_DP0]} =
		data_parity_line_in;

	// Remaining single cells; control cells capture their own update bit.
	assign {cap[C_STEST], cap[C_ONCE], cap[C_BACKOFF], cap[C_BTERM],
		cap[C_READY], cap[C_HOLD], cap[C_NMI], cap[C_RESET], cap[C_CLKIN]} =
		pin_in[16:8];
	assign {cap[C_FAIL], cap[C_STALL], cap[C_BUS_REQUEST_PENDING], cap[C_BUS_GRANT_ACK],
		cap[C_ADS]} = ctl_out[17:13];
	assign {cap[C_BLAST], cap[C_DEN], cap[C_WRRD], cap[C_WAIT], cap[C_DC],
		cap[C_SUP], cap[C_LOCK], cap[C_DTR], cap[C_PCHK]} = ctl_out[8:0];
	assign {cap[C_EN_FAIL], cap[C_EN_DATA], cap[C_EN_BUS_GRANT_ACK], cap[C_EN_DTR],
		cap[C_EN_BUS], cap[C_EN_ADDR], cap[C_EN_PCHK]} =
		{upd_reg[C_EN_FAIL], upd_reg[C_EN_DATA], upd_reg[C_EN_BUS_GRANT_ACK],
		upd_reg[C_EN_DTR], upd_reg[C_EN_BUS], upd_reg[C_EN_ADDR],
		upd_reg[C_EN_PCHK]};
endmodule : bsc_chain_front

// ---- inc/bsc_pkg.sv ----
// Package of cell positions and group codes for the boundary-scan chain.
package bsc_pkg;
	localparam int BSC_LEN = 112;
	localparam logic BSC_RST_BIT = 1'b0;
	// Synchroniser depth for pins sampled from the test side.
	localparam int BSC_SYNC_STAGES = 2;
	// Cell positions, zero based: position 0 is next to the serial output.
	localparam int C_DP3 = 0;
	localparam int C_DP2 = 1;
	localparam int C_DP0 = 2;
	localparam int C_DP1 = 3;
	localparam int C_STEST = 4;
	localparam int C_FAIL = 5;
	localparam int C_EN_FAIL = 6;
	localparam int C_ONCE = 7;
	localparam int C_BACKOFF = 8;
	localparam int C_D0 = 9;
	localparam int C_EN_DATA = 17;
	localparam int C_D8 = 18;
	localparam int C_BTERM = 42;
	localparam int C_READY = 43;
	localparam int C_HOLD = 44;
	localparam int C_BUS_GRANT_ACK = 45;
	localparam int C_EN_BUS_GRANT_ACK = 46;
	localparam int C_ADS = 47;
	localparam int C_BE0 = 51;
	localparam int C_BLAST = 52;
	localparam int C_DEN = 53;
	localparam int C_WRRD = 54;
	localparam int C_DTR = 55;
	localparam int C_EN_DTR = 56;
	localparam int C_WAIT = 57;
	localparam int C_STALL = 58;
	localparam int C_DC = 59;
	localparam int C_SUP = 60;
	localparam int C_EN_BUS = 61;
	localparam int C_LOCK = 62;
	localparam int C_BUS_REQUEST_PENDING = 63;
	localparam int C_A16 = 79;
	localparam int C_EN_ADDR = 80;
	localparam int C_A2 = 94;
	localparam int C_NMI = 95;
	localparam int C_XINT0 = 103;
	localparam int C_RESET = 104;
	localparam int C_CLKIN = 105;
	localparam int C_CT0 = 109;
	localparam int C_PCHK = 110;
	localparam int C_EN_PCHK = 111;
	// Indices of the functional enable vector, one per control cell.
	localparam int G_FAIL = 0;
	localparam int G_DATA = 1;
	localparam int G_BUS_GRANT_ACK = 2;
	localparam int G_DTR = 3;
	localparam int G_BUS = 4;
	localparam int G_ADDR = 5;
	localparam int G_PCHK = 6;
	localparam int G_NUM = 7;
endpackage : bsc_pkg

// ---- dv/bsc_chain_front_checker.sv ----
// Port checks for the boundary-scan chain front.
module bsc_chain_front_checker
	import bsc_pkg::*;
(
	input wire logic ref_clk, // Clock.
	input wire logic resetn, // Reset, active low.
	input wire logic tck, // Test clock.
	input wire logic shift_dr, // Shift state.
	input wire logic update_dr, // Update state.
	input wire logic extest, // Pin test mode.
	input wire logic tdo, // Serial out.
	input wire logic tdo_oe_n, // Serial out enable.
	input wire logic [G_NUM-1:0] core_en, // Functional enables.
	input wire logic [31:0] core_data, // Functional data.
	input wire logic [29:0] core_addr, // Functional address.
	input wire logic [31:0] data_line_out, // Data pins.
	input wire logic data_line_oe_n, // Data enable.
	input wire logic data_parity_line_oe_n, // Parity enable.
	input wire logic grp_fail_oe_n, // Failure group enable.
	input wire logic bus_grant_ack_oe_n, // Grant enable.
	input wire logic address_strobe_n, // Address strobe.
	input wire logic grp_bus_oe_n, // Bus group enable.
	input wire logic [29:0] address, // Address pins.
	input wire logic grp_addr_oe_n // Address group enable.
);
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// Enables of grouped pins and the serial output.
	AST_OE_PAIR: assert property (data_line_oe_n == data_parity_line_oe_n)
		else $error("data and parity enables differ");
	AST_TDO_ON: assert property ($rose(shift_dr) |-> ##[1:3] !tdo_oe_n)
		else $error("serial output not driven in shift");
	AST_TDO_OFF: assert property (!shift_dr [*4] |-> tdo_oe_n)
		else $error("serial output driven outside shift");
	AST_TDO_HOLD: assert property ($stable(tck) [*7] |-> $stable(tdo))
		else $error("serial output moved without test clock");
	// Pins in test mode hold between updates.
	AST_BUS_HOLD: assert property ((extest && !update_dr) [*6] |->
		$stable(grp_bus_oe_n) && $stable(address_strobe_n))
		else $error("bus group moved without update");
	AST_ADDR_HOLD: assert property ((extest && !update_dr) [*6] |->
		$stable(address) && $stable(grp_addr_oe_n))
		else $error("address group moved without update");
	// Functional mode follows the core.
	AST_FUNC_DATA: assert property (!extest [*4] |-> data_line_out == core_data
		&& data_line_oe_n == !core_en[G_DATA])
		else $error("data pins differ from core");
	AST_FUNC_CTL: assert property (!extest [*4] |-> grp_fail_oe_n ==
		!core_en[G_FAIL] && bus_grant_ack_oe_n == !core_en[G_BUS_GRANT_ACK])
		else $error("control enables differ from core");
	AST_FUNC_ADDR: assert property (!extest [*4] |-> address == core_addr
		&& grp_addr_oe_n == !core_en[G_ADDR])
		else $error("address pins differ from core");
	// Main scenarios reached.
	COV_SHIFT: cover property (shift_dr && $rose(tck));
	COV_UPDATE: cover property (extest && update_dr && $fell(tck));
	COV_MODE: cover property ($rose(extest));
endmodule : bsc_chain_front_checker

bind bsc_chain_front bsc_chain_front_checker chk_i (.*);

// ---- dv/bsc_tap_model.sv ----
// Test-port partner that walks capture, shift and update frames.
module bsc_tap_model
(
	output logic tck, // Test clock, still between frames.
	output logic tdi, // Serial data to the chain.
	output logic capture_dr, // Capture state.
	output logic shift_dr, // Shift state.
	output logic update_dr, // Update state.
	input wire logic tdo // Serial data from the chain.
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle levels at start.
	initial
	begin
		tck = 1'b0;
		tdi = 1'b0;
		capture_dr = 1'b0;
		shift_dr = 1'b0;
		update_dr = 1'b0;
	end
	// One frame of 320 ns test clocks; bit 0 enters first, ends in cell one.
	task automatic scan(input logic [111:0] din, output logic [111:0] dout);
		#1 capture_dr = 1'b1;
		#160 tck = 1'b1;
		#160 tck = 1'b0;
		capture_dr = 1'b0;
		shift_dr = 1'b1;
		for (int i = 0; i < 112; i++)
		begin
			tdi = din[i];
			#150 dout[i] = tdo;
			#10 tck = 1'b1;
			#160 tck = 1'b0;
		end
		shift_dr = 1'b0;
		tdi = ~tdi;
		update_dr = 1'b1;
		#160 tck = 1'b1;
		#160 tck = 1'b0;
		#160 update_dr = 1'b0;
	endtask : scan
endmodule : bsc_tap_model

// ---- dv/testbench.sv ----
// Bench for the boundary-scan chain front.
module testbench
	import bsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
	err_count++; $display("BAD %s exp %h got %h", n, e, s); end end
	logic ref_clk, resetn, tck, tdi, capture_dr, shift_dr, update_dr, extest;
	logic tdo, tdo_oe_n, data_line_oe_n, data_parity_line_oe_n, data_dir_n;
	logic selftest_failure_n, bus_stall_indication, bus_request_pending;
	logic grp_fail_oe_n, bus_grant_ack, bus_grant_ack_oe_n, address_strobe_n;
	logic final_transfer_n, data_strobe_enable_n, write_read_select;
	logic wait_indicator_n, data_code_select, privilege_level_n, atomic_lock_n;
	logic grp_bus_oe_n, data_dir_oe_n, grp_addr_oe_n;
	logic parity_check_n, parity_check_oe_n;
	logic [G_NUM-1:0] core_en;
	logic [31:0] core_data, data_line_in, data_line_out;
	logic [3:0] core_parity, core_ct, data_parity_line_in, data_parity_line_out;
	logic [3:0] byte_lane_enable_n, cycle_type;
	logic [18:0] core_ctl;
	logic [29:0] core_addr, address;
	logic [16:0] pin_in;
	logic [111:0] v, got, prev;
	logic [191:0] r;
	integer seed, err_count, compares;
	bsc_chain_front bsc_chain_front_i (.*);
	bsc_tap_model bsc_tap_model_i (.*);
	// Clock of 40 ns.
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	function automatic logic [191:0] rv();
		logic [191:0] t;
		t = '0;
		repeat (6) t = {t[159:0], $random(seed)};
		return t;
	endfunction : rv
	// Random core values and pin levels.
	task automatic rnd;
		r = rv();
		{core_en, core_data, core_parity, core_ctl, core_addr, core_ct,
			data_line_in, data_parity_line_in, pin_in} <= r[148:0];
	endtask : rnd
	// Expected capture: pins for input and bidirectional cells, else update.
	function automatic logic [111:0] cap_exp(logic [111:0] u);
		logic [111:0] e;
		logic [3:0] p;
		e = u;
		p = data_parity_line_in;
		e[3:0] = {p[1], p[0], p[2], p[3]};
		e[C_STEST] = pin_in[16];
		e[8:7] = {pin_in[14], pin_in[15]};
		e[16:9] = data_line_in[7:0];
		e[41:18] = data_line_in[31:8];
		e[44:42] = {pin_in[11], pin_in[12], pin_in[13]};
		e[C_NMI] = pin_in[10];
		e[105:104] = {pin_in[8], pin_in[9]};
		for (int k = 0; k < 8; k++)
			e[C_XINT0 - k] = pin_in[k];
		return e;
	endfunction : cap_exp
	task automatic func_chk;
		repeat (3)
		begin
			@(posedge ref_clk);
			rnd();
			repeat (5) @(posedge ref_clk);
			#1;
			`CHK("data", core_data, data_line_out)
			`CHK("bus oe", ~core_en[G_BUS], grp_bus_oe_n)
			`CHK("addr", core_addr, address)
			`CHK("ct", core_ct, cycle_type)
			`CHK("par", core_parity, data_parity_line_out)
		end
	endtask : func_chk
	task automatic print_verdict;
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Main sequence: functional mode, pin test frames, functional again.
	initial
	begin
		seed = 17;
		err_count = 0;
		compares = 0;
		prev = '0;
		resetn <= 1'b0;
		extest <= 1'b0;
		rnd();
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		func_chk();
		extest <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge ref_clk);
			rnd();
			v = (i == 0) ? '1 : (i == 1) ? '0 : rv();
			repeat (4) @(posedge ref_clk);
			bsc_tap_model_i.scan(v, got);
			`CHK("chain", cap_exp(prev), got)
			repeat (5) @(posedge ref_clk);
			#1;
			`CHK("fail oe", ~v[C_EN_FAIL], grp_fail_oe_n)
			`CHK("data oe", ~v[C_EN_DATA], data_line_oe_n)
			`CHK("par oe", ~v[C_EN_DATA], data_parity_line_oe_n)
			`CHK("ack oe", ~v[C_EN_BUS_GRANT_ACK], bus_grant_ack_oe_n)
			`CHK("bus oe", ~v[C_EN_BUS], grp_bus_oe_n)
			`CHK("addr oe", ~v[C_EN_ADDR], grp_addr_oe_n)
			`CHK("pchk oe", ~v[C_EN_PCHK], parity_check_oe_n)
			`CHK("data", {v[41:18], v[16:9]}, data_line_out)
			`CHK("fail", v[C_FAIL], selftest_failure_n)
			`CHK("stall", v[C_STALL], bus_stall_indication)
			`CHK("bus_request_pending", v[C_BUS_REQUEST_PENDING], bus_request_pending)
			`CHK("ack", v[C_BUS_GRANT_ACK], bus_grant_ack)
			`CHK("ads", v[C_ADS], address_strobe_n)
			`CHK("be0", v[C_BE0], byte_lane_enable_n[0])
			`CHK("lock", v[C_LOCK], atomic_lock_n)
			`CHK("a2", v[C_A2], address[0])
			`CHK("a31", v[C_A16-15], address[29])
			`CHK("ct0", v[C_CT0], cycle_type[0])
			`CHK("dp", {v[C_DP3], v[C_DP2], v[C_DP1], v[C_DP0]}, data_parity_line_out)
			prev = v;
		end
		extest <= 1'b0;
		func_chk();
		print_verdict();
	end
	// Watchdog well past six frames of about 37 us each.
	initial
	begin
		#600_000;
		err_count++;
		print_verdict();
	end
endmodule : testbench
